// ### rtl/sec_pkg.sv
// constants and types shared by both ends of the serial EEPROM link
// Functional notes
// - 8192 bits, x16 or x8 addressing
// - start bit, opcode, address, optional data
// - 13 or 14 bit frames, seven commands
// - opcodes: 10 read, 11 clear, 01 write
// - opcode 00: top address bits pick special
// - host sends ignored top address bit defined
// - input bits sampled on rising clock
// - output floats except read or status
// - reselect shows status: low busy, high ready
// - shifted one releases status at falling edge
// - host releases status output after polling
// - read sends zero then word, msb first
// - read output changes on rising edge
// - sequential read increments, wraps to zero
// - only first word gets leading zero
// - select low starts self-timed cycle
// - program cycle needs no serial clock
// - write clears location before storing
// - programming disabled until enable command
// - clear leaves affected bits at one
// - select must drop before next rising edge
package sec_pkg;
	localparam int AW16 = 10;
	localparam int AW8 = 11;
	localparam int DW16 = 16;
	localparam int DW8 = 8;
	localparam int MEM_BYTES = 1024;
	localparam int FRAME_W = 29;
	localparam logic [1:0] OP_SPECIAL = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_CLEAR = 2'h3;
	localparam logic [1:0] SP_DISABLE = 2'h0;
	localparam logic [1:0] SP_WRITE_ALL = 2'h1;
	localparam logic [1:0] SP_CLEAR_ALL = 2'h2;
	localparam logic [1:0] SP_ENABLE = 2'h3;
	localparam logic [7:0] CLEARED_BYTE = 8'hff;
	localparam int SYS_PERIOD_NS = 100;
	localparam int PROGRAM_CYCLE_TIME_MS = 5;
	localparam real MIN_SELECT_LOW_TIME_US = 0.25;
	localparam real OUTPUT_DELAY_HIGH_US = 0.25;
	localparam real SK_MIN_HALF_US = 0.25;
	localparam int PROG_CYC_DEF =
		PROGRAM_CYCLE_TIME_MS * 1000000 / SYS_PERIOD_NS;
	localparam int SEL_LOW_CYC =
		int'($ceil(MIN_SELECT_LOW_TIME_US * 1000.0 / SYS_PERIOD_NS));
	localparam int OUT_DLY_CYC =
		int'($floor(OUTPUT_DELAY_HIGH_US * 1000.0 / SYS_PERIOD_NS));
	localparam int HALF_CYC =
		int'($ceil(SK_MIN_HALF_US * 1000.0 / SYS_PERIOD_NS));
	localparam int STAT_CYC = OUT_DLY_CYC + 3;
	typedef enum logic [2:0] {
		CMD_READ, CMD_WRITE, CMD_CLEAR, CMD_PROGRAM_ENABLE,
		CMD_PROGRAM_DISABLE, CMD_CLEAR_WHOLE_ARRAY,
		CMD_PROGRAM_WHOLE_ARRAY
	} sec_cmd_e;
endpackage : sec_pkg

// ### rtl/sec_link_if.sv
// link between the host controller and the serial EEPROM
`timescale 1ns/100ps
interface sec_link_if;
	logic cs;              // chip select, high selects
	logic serial_clock_in; // link clock made by the host
	logic serial_data_in;  // host to device data
	logic data_out;        // device output value
	logic data_out_oe;     // device drives data_out
	logic data_line;       // resolved output wire
	// idle line pulled high, so an undriven poll reads ready
	assign data_line = data_out_oe ? data_out : 1'b1;
	modport device (input cs, serial_clock_in, serial_data_in,
		output data_out, data_out_oe);
	modport host (output cs, serial_clock_in, serial_data_in,
		input data_line);
endinterface : sec_link_if

// ### rtl/sec_sync.sv
// two-flop level synchroniser
`timescale 1ns/100ps
module sec_sync #(
	parameter int W = 1
) (
	input  wire logic         clk, // destination clock
	input  wire logic         rst, // async reset, high
	input  wire logic [W-1:0] d,   // foreign level
	output logic      [W-1:0] q    // synchronised level
);
	typedef struct packed {
		logic [W-1:0] m;
		logic [W-1:0] q;
	} sec_sync_s;
	sec_sync_s s;
	sec_sync_s next_s;
	always_comb begin
		next_s.m = d;
		next_s.q = s.m;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end
	assign q = s.q;
endmodule : sec_sync

// ### rtl/sec_device.sv
// serial EEPROM device end: link-clock command logic, self-timed array
`timescale 1ns/100ps
module sec_device
	import sec_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYC_DEF
) (
	sec_link_if.device link,    // serial link
	input  wire logic  clk_sys, // internal timing clock
	input  wire logic  rst,     // async reset, high
	input  wire logic  org_word, // high: x16, low: x8
	output logic       busy     // program cycle running
);
	localparam int TW = $clog2(PROG_CYC + 1);

	typedef enum logic [4:0] {
		LK_IDLE = 5'h01,
		LK_HDR  = 5'h02,
		LK_DATA = 5'h04,
		LK_READ = 5'h08,
		LK_DONE = 5'h10
	} sec_lk_e;

	typedef enum logic [1:0] {
		PG_IDLE = 2'h1,
		PG_RUN  = 2'h2
	} sec_pg_e;

	typedef struct packed {
		sec_lk_e     st;
		logic [4:0]  cnt;
		logic [12:0] hdr;
		logic [15:0] dat;
		logic [9:0]  ra;
		logic [3:0]  bix;
		logic        rd_oe;
		logic        rd_bit;
		logic        en;
		logic        armed;
		logic        tgl;
		logic        one;
	} sec_lk_s;

	typedef struct packed {
		sec_pg_e     st;
		logic        cs_d;
		logic        seen;
		logic        stat;
		logic        erase;
		logic        walk;
		logic [9:0]  ptr;
		logic [9:0]  hi;
		logic [15:0] dat;
		logic [TW-1:0] tmr;
	} sec_pg_s;

	sec_lk_s     l;
	sec_lk_s     next_l;
	sec_pg_s     p;
	sec_pg_s     next_p;
	logic [7:0]  mem [MEM_BYTES];
	logic        rel;
	logic [1:0]  lk_sync;
	logic [4:0]  pg_sync;
	logic        busy_l;
	logic        org_l;
	logic        cs_c;
	logic        armed_c;
	logic        tgl_c;
	logic        rel_c;
	logic        org_c;
	logic [1:0]  op_h;
	logic [1:0]  sp_h;
	logic [9:0]  wa_h;

	sec_sync #(.W(2)) u_lk_sync (
		.clk (link.serial_clock_in),
		.rst (rst),
		.d   ({p.st == PG_RUN, org_word}),
		.q   (lk_sync)
	);
	assign busy_l = lk_sync[1];
	assign org_l  = lk_sync[0];

	sec_sync #(.W(5)) u_pg_sync (
		.clk (clk_sys),
		.rst (rst),
		.d   ({link.cs, l.armed, l.tgl, rel, org_word}),
		.q   (pg_sync)
	);
	assign {cs_c, armed_c, tgl_c, rel_c, org_c} = pg_sync;

	// header fields, held still while a command waits for deselect
	assign op_h = org_l ? l.hdr[11:10] : l.hdr[12:11];
	assign sp_h = org_l ? l.hdr[9:8] : l.hdr[10:9];
	assign wa_h = org_l ? {1'b0, l.hdr[8:0]} : l.hdr[9:0];

	// link clock domain: frame decode and read streaming
	always_comb begin
		logic [12:0] nh;
		logic [1:0]  op;
		logic [1:0]  sp;
		logic [9:0]  wa;
		logic [4:0]  hl;
		logic [4:0]  dw;
		logic [15:0] word;
		nh = {l.hdr[11:0], link.serial_data_in};
		op = org_l ? nh[11:10] : nh[12:11];
		sp = org_l ? nh[9:8] : nh[10:9];
		wa = org_l ? {1'b0, nh[8:0]} : nh[9:0];
		hl = org_l ? 5'(AW16 + 2) : 5'(AW8 + 2);
		dw = org_l ? 5'(DW16) : 5'(DW8);
		word = org_l ? {mem[{l.ra[8:0], 1'b0}], mem[{l.ra[8:0], 1'b1}]}
			: {8'h00, mem[l.ra]};
		next_l = l;
		next_l.one = link.cs & link.serial_data_in;
		if (!link.cs || !rel) begin
			next_l.st = LK_IDLE;
			next_l.rd_oe = 1'b0;
		end
		if (link.cs) begin
			next_l.armed = 1'b0;
			unique case (rel ? l.st : LK_IDLE)
				LK_IDLE: begin
					// a start bit during a program cycle is dropped
					if (link.serial_data_in && !busy_l) begin
						next_l.st = LK_HDR;
						next_l.cnt = 5'h00;
					end
				end
				LK_HDR: begin
					next_l.hdr = nh;
					next_l.cnt = l.cnt + 5'h01;
					if (l.cnt == hl - 5'h01) begin
						next_l.cnt = 5'h00;
						next_l.st = LK_DONE;
						unique case (op)
							OP_READ: begin
								next_l.st = LK_READ;
								next_l.rd_oe = 1'b1;
								next_l.rd_bit = 1'b0;
								next_l.ra = wa;
								next_l.bix = 4'(dw - 5'h01);
							end
							OP_CLEAR: begin
								next_l.armed = l.en;
								next_l.tgl = l.tgl ^ l.en;
							end
							OP_WRITE:
								next_l.st = LK_DATA;
							OP_SPECIAL: begin
								unique case (sp)
									SP_ENABLE:
										next_l.en = 1'b1;
									SP_DISABLE:
										next_l.en = 1'b0;
									SP_CLEAR_ALL: begin
										next_l.armed = l.en;
										next_l.tgl = l.tgl ^ l.en;
									end
									SP_WRITE_ALL:
										next_l.st = LK_DATA;
								endcase
							end
						endcase
					end
				end
				LK_DATA: begin
					next_l.dat = {l.dat[14:0], link.serial_data_in};
					next_l.cnt = l.cnt + 5'h01;
					if (l.cnt == dw - 5'h01) begin
						next_l.st = LK_DONE;
						next_l.armed = l.en;
						next_l.tgl = l.tgl ^ l.en;
					end
				end
				LK_READ: begin
					next_l.rd_bit = word[l.bix];
					if (l.bix == 4'h0) begin
						// no leading zero before later words
						next_l.bix = 4'(dw - 5'h01);
						next_l.ra = org_l
							? {1'b0, 9'(l.ra[8:0] + 9'h001)}
							: 10'(l.ra + 10'h001);
					end else begin
						next_l.bix = l.bix - 4'h1;
					end
				end
				LK_DONE: ;
			endcase
		end
	end

	always_ff @(posedge link.serial_clock_in or posedge rst) begin
		if (rst)
			l <= '{st: LK_IDLE, default: '0};
		else
			l <= next_l;
	end

	// first one of a selection: opens the frame, releases status
	always_ff @(negedge link.serial_clock_in or negedge link.cs
		or posedge rst) begin
		if (rst)
			rel <= 1'b0;
		else if (!link.cs)
			rel <= 1'b0;
		else if (l.one)
			rel <= 1'b1;
	end

	// internal clock domain: self-timed program cycle
	always_comb begin
		logic start;
		logic whole;
		start = p.cs_d & ~cs_c;
		whole = op_h == OP_SPECIAL;
		next_p = p;
		next_p.cs_d = cs_c;
		if (rel_c)
			next_p.stat = 1'b0;
		if (start) begin
			// each armed command is consumed at one deselect only
			next_p.seen = tgl_c;
			if (armed_c && tgl_c != p.seen && p.st == PG_IDLE) begin
				next_p.st = PG_RUN;
				next_p.stat = 1'b1;
				next_p.walk = 1'b1;
				next_p.tmr = '0;
				next_p.dat = l.dat;
				next_p.erase = op_h == OP_CLEAR
					|| (whole && sp_h == SP_CLEAR_ALL);
				next_p.ptr = whole ? 10'h000
					: org_c ? {wa_h[8:0], 1'b0} : wa_h;
				next_p.hi = whole ? 10'(MEM_BYTES - 1)
					: org_c ? {wa_h[8:0], 1'b1} : wa_h;
			end
		end
		if (p.st == PG_RUN) begin
			next_p.tmr = TW'(p.tmr + 1'b1);
			if (p.walk) begin
				if (p.ptr == p.hi)
					next_p.walk = 1'b0;
				else
					next_p.ptr = p.ptr + 10'h001;
			end
			if (p.tmr == TW'(PROG_CYC - 1) && !p.walk)
				next_p.st = PG_IDLE;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			p <= '{st: PG_IDLE, default: '0};
		else
			p <= next_p;
	end

	// stored value replaces the old one, so the clear is implicit
	always_ff @(posedge clk_sys) begin
		if (p.st == PG_RUN && p.walk)
			mem[p.ptr] <= p.erase ? CLEARED_BYTE
				: !org_c ? p.dat[7:0]
				: p.ptr[0] ? p.dat[7:0] : p.dat[15:8];
	end

	assign busy = p.st == PG_RUN;
	// data comes from flops; enable follows select directly
	assign link.data_out = l.rd_oe & rel ? l.rd_bit
		: p.st == PG_IDLE;
	assign link.data_out_oe = l.rd_oe & rel
		| (link.cs & p.stat & ~rel);
endmodule : sec_device

// ### rtl/sec_host.sv
// serial EEPROM host end: makes the link clock, sends frames, polls
`timescale 1ns/100ps
module sec_host
	import sec_pkg::*;
(
	sec_link_if.host    link,      // serial link
	input  wire logic   clk_sys,   // system clock
	input  wire logic   rst,       // async reset, high
	input  wire logic   org_word,  // device wired x16 when high
	input  wire logic   cmd_valid, // command request
	output logic        cmd_ready, // host idle
	input  sec_cmd_e    cmd_op,    // command
	input  wire logic [10:0] cmd_addr,  // address
	input  wire logic [15:0] cmd_data,  // write data
	input  wire logic [9:0]  cmd_words, // words to read, 0 = 1024
	output logic        rd_valid,  // read word pulse
	output logic [15:0] rd_word,   // read word
	output logic        done       // command finished pulse
);
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_SEND  = 5'h02,
		H_RECV  = 5'h04,
		H_DESEL = 5'h08,
		H_POLL  = 5'h10
	} sec_host_e;

	typedef struct packed {
		sec_host_e   st;
		logic [3:0]  ph;
		logic        clk_o;
		logic        cs;
		logic        dout;
		logic [FRAME_W-1:0] tx;
		logic [4:0]  left;
		logic        rd;
		logic        prog;
		logic        x16;
		logic        first;
		logic [15:0] rx;
		logic [4:0]  rbits;
		logic [9:0]  words;
		logic [3:0]  wt;
		logic        rv;
		logic [15:0] rw;
		logic        done;
	} sec_host_s;

	sec_host_s s;
	sec_host_s next_s;
	logic      line_s;

	sec_sync #(.W(1)) u_line_sync (
		.clk (clk_sys),
		.rst (rst),
		.d   (link.data_line),
		.q   (line_s)
	);

	always_comb begin
		logic [1:0]  op;
		logic [10:0] ad;
		logic        wr;
		logic        tick;
		logic [15:0] v;
		op = OP_SPECIAL;
		ad = cmd_addr;
		wr = 1'b0;
		unique case (cmd_op)
			CMD_READ: op = OP_READ;
			CMD_WRITE: begin
				op = OP_WRITE;
				wr = 1'b1;
			end
			CMD_CLEAR: op = OP_CLEAR;
			CMD_PROGRAM_ENABLE: ad = {SP_ENABLE, 9'h000};
			CMD_PROGRAM_DISABLE: ad = {SP_DISABLE, 9'h000};
			CMD_CLEAR_WHOLE_ARRAY: ad = {SP_CLEAR_ALL, 9'h000};
			CMD_PROGRAM_WHOLE_ARRAY: begin
				ad = {SP_WRITE_ALL, 9'h000};
				wr = 1'b1;
			end
		endcase
		// x16 has one address bit fewer, so the code bits move down
		if (org_word && op == OP_SPECIAL)
			ad = {1'b0, ad[10:1]};
		tick = s.ph == 4'(HALF_CYC - 1);
		v = {s.rx[14:0], line_s};
		next_s = s;
		next_s.rv = 1'b0;
		next_s.done = 1'b0;
		unique case (s.st)
			H_IDLE: begin
				if (cmd_valid) begin
					// frame left aligned, start bit first
					next_s.tx = org_word
						? {1'b1, op, ad[9:0], cmd_data}
						: {1'b1, op, ad, cmd_data[7:0], 7'h00};
					next_s.left = 5'(1 + 2 + (org_word ? AW16 : AW8)
						+ (wr ? (org_word ? DW16 : DW8) : 0));
					next_s.x16 = org_word;
					next_s.rd = cmd_op == CMD_READ;
					next_s.prog = wr || cmd_op == CMD_CLEAR
						|| cmd_op == CMD_CLEAR_WHOLE_ARRAY;
					next_s.words = cmd_words;
					next_s.cs = 1'b1;
					next_s.ph = 4'h0;
					next_s.clk_o = 1'b0;
					next_s.dout = 1'b1;
					next_s.tx = next_s.tx << 1;
					next_s.st = H_SEND;
				end
			end
			H_SEND: begin
				next_s.ph = tick ? 4'h0 : s.ph + 4'h1;
				if (tick) begin
					next_s.clk_o = ~s.clk_o;
					if (s.clk_o) begin
						if (s.left == 5'h01) begin
							next_s.first = 1'b1;
							next_s.rbits = s.x16 ? 5'(DW16) : 5'(DW8);
							next_s.st = s.rd ? H_RECV : H_DESEL;
							next_s.cs = s.rd;
							next_s.wt = 4'h0;
						end else begin
							next_s.dout = s.tx[FRAME_W-1];
							next_s.tx = s.tx << 1;
							next_s.left = s.left - 5'h01;
						end
					end
				end
			end
			H_RECV: begin
				next_s.ph = tick ? 4'h0 : s.ph + 4'h1;
				if (tick) begin
					next_s.clk_o = ~s.clk_o;
					// sample the bit set by the previous rising edge
					if (!s.clk_o) begin
						if (s.first) begin
							next_s.first = 1'b0;
						end else begin
							next_s.rx = v;
							next_s.rbits = s.rbits - 5'h01;
							if (s.rbits == 5'h01) begin
								next_s.rv = 1'b1;
								next_s.rw = s.x16 ? v : {8'h00, v[7:0]};
								next_s.rbits = s.x16 ? 5'(DW16) : 5'(DW8);
								next_s.words = s.words - 10'h001;
								if (s.words == 10'h001) begin
									next_s.clk_o = 1'b0;
									next_s.cs = 1'b0;
									next_s.wt = 4'h0;
									next_s.st = H_DESEL;
								end
							end
						end
					end
				end
			end
			H_DESEL: begin
				next_s.cs = 1'b0;
				next_s.wt = s.wt + 4'h1;
				if (s.wt == 4'(SEL_LOW_CYC - 1)) begin
					next_s.wt = 4'h0;
					if (s.prog) begin
						next_s.cs = 1'b1;
						next_s.st = H_POLL;
					end else begin
						next_s.done = 1'b1;
						next_s.st = H_IDLE;
					end
				end
			end
			H_POLL: begin
				if (s.wt != 4'(STAT_CYC))
					next_s.wt = s.wt + 4'h1;
				else if (line_s) begin
					// dropping select floats a shared data line
					next_s.cs = 1'b0;
					next_s.prog = 1'b0;
					next_s.wt = 4'h0;
					next_s.st = H_DESEL;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			s <= '{st: H_IDLE, default: '0};
		else
			s <= next_s;
	end

	assign cmd_ready = s.st == H_IDLE;
	assign rd_valid = s.rv;
	assign rd_word = s.rw;
	assign done = s.done;
	assign link.cs = s.cs;
	assign link.serial_clock_in = s.clk_o;
	assign link.serial_data_in = s.dout;
endmodule : sec_host

// ### verif/sec_link_sva.sv
// assertions on the serial link between the host and device ends
`timescale 1ns/100ps
module sec_link_sva #(
	parameter int PROG_CYC = 1100
) (
	input wire logic clk_sys,         // system clock
	input wire logic rst,             // async reset, high
	input wire logic org_word,        // high: x16 framing
	input wire logic cs,              // chip select
	input wire logic serial_clock_in, // link clock
	input wire logic serial_data_in,  // host to device data
	input wire logic data_out,        // device output value
	input wire logic data_out_oe,     // device drives output
	input wire logic busy             // program cycle running
);
	logic        sclk_q;
	logic        cs_q;
	logic        pend;
	logic [15:0] edges;
	logic [15:0] hdr;
	logic [15:0] dw;
	int unsigned busy_len;

	assign hdr = org_word ? 16'h000d : 16'h000e;
	assign dw  = org_word ? 16'h0010 : 16'h0008;

	// link edges seen through clk_sys: the host makes them from it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_q   <= 1'b0;
			cs_q     <= 1'b0;
			pend     <= 1'b0;
			edges    <= 16'h0000;
			busy_len <= 0;
		end else begin
			sclk_q   <= serial_clock_in;
			cs_q     <= cs;
			busy_len <= busy ? busy_len + 1 : 0;
			if (cs && !cs_q)
				edges <= 16'h0000;
			else if (cs && serial_clock_in && !sclk_q)
				edges <= edges + 16'h0001;
			if (cs && !cs_q)
				pend <= 1'b1;
			else if (!cs || (serial_clock_in && !sclk_q))
				pend <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_float_idle: assert property (!cs [*3] |-> !data_out_oe)
		else $error("output driven while deselected");
	a_status_busy: assert property (busy && data_out_oe |-> !data_out)
		else $error("ready shown while busy");
	a_busy_span: assert property ($fell(busy) |-> busy_len == PROG_CYC)
		else $error("program cycle length wrong");
	a_start_deselect: assert property (
		$rose(busy) |-> !$past(cs) && $past(cs, 4))
		else $error("program started without deselect");
	a_read_edge: assert property (
		cs && data_out_oe && $past(data_out_oe) && $changed(data_out)
		&& !busy && !$past(busy) && !$past(busy, 2)
		|-> $rose(serial_clock_in))
		else $error("read bit changed off rising link edge");
	a_start_bit: assert property (
		pend && serial_clock_in && !sclk_q |-> serial_data_in)
		else $error("frame without start bit");
	a_frame_len: assert property (
		$fell(cs) |-> edges == 16'h0000
		|| (edges >= hdr && (edges - hdr) % dw == 16'h0000))
		else $error("frame length wrong");
	a_select_gap: assert property ($fell(cs) |-> !cs [*3])
		else $error("select low time too short");
	a_select_early: assert property ($fell(cs) |-> !serial_clock_in)
		else $error("select dropped with clock high");
	a_data_setup: assert property (
		cs && $changed(serial_data_in) |-> !serial_clock_in)
		else $error("data changed with clock high");

	c_program: cover property ($fell(busy));
	c_ready: cover property (cs && data_out_oe && data_out && !busy);
	c_long_read: cover property ($fell(cs) && edges > 16'h0020);
endmodule : sec_link_sva

// ### verif/sec_bench.sv
// self-checking bench: host and device ends joined by the link
`timescale 1ns/100ps
module sec_bench;
	import sec_pkg::*;
	localparam int PCYC = 1100;
	logic        clk_sys;
	logic        rst;
	logic        org_word;
	logic        cmd_valid;
	logic        cmd_ready;
	sec_cmd_e    cmd_op;
	logic [10:0] cmd_addr;
	logic [15:0] cmd_data;
	logic [9:0]  cmd_words;
	logic        rd_valid;
	logic [15:0] rd_word;
	logic        done;
	logic        busy;
	logic [15:0] got[$];
	int          num_errors;
	int          comparisons;
	int          seed;

	sec_link_if link();
	sec_device #(.PROG_CYC(PCYC)) sec_device_inst (.link(link),
		.clk_sys(clk_sys), .rst(rst), .org_word(org_word), .busy(busy));
	sec_host sec_host_inst (.link(link), .clk_sys(clk_sys), .rst(rst),
		.org_word(org_word), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .cmd_words(cmd_words),
		.rd_valid(rd_valid), .rd_word(rd_word), .done(done));
	sec_link_sva #(.PROG_CYC(PCYC)) sec_link_sva_inst (.clk_sys(clk_sys),
		.rst(rst), .org_word(org_word), .cs(link.cs),
		.serial_clock_in(link.serial_clock_in),
		.serial_data_in(link.serial_data_in), .data_out(link.data_out),
		.data_out_oe(link.data_out_oe), .busy(busy));

	always #50 clk_sys = ~clk_sys;

	function automatic logic [15:0] fit(input logic [15:0] d);
		return org_word ? d : {8'h00, d[7:0]};
	endfunction : fit

	task automatic close_out;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reset_dut(input logic org);
		@(negedge clk_sys);
		rst = 1'b1;
		org_word = org;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask : reset_dut

	// one command through the host port, read words gathered in got
	task automatic run(input sec_cmd_e op, input logic [10:0] a,
		input logic [15:0] d, input logic [9:0] n);
		int k;
		got.delete();
		k = 0;
		while (cmd_ready !== 1'b1 && k < 100) begin
			@(negedge clk_sys);
			k++;
		end
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_words = n;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 20000) begin
			if (rd_valid === 1'b1)
				got.push_back(rd_word);
			@(negedge clk_sys);
			k++;
		end
		check("command done", 16'h0001, {15'h0000, done});
	endtask : run

	// first word e0, every later word e1
	task automatic read_expect(input logic [10:0] a, input logic [15:0] e0,
		input logic [15:0] e1, input int n);
		run(CMD_READ, a, 16'h0000, n[9:0]);
		check("word count", n[15:0], 16'(got.size()));
		foreach (got[i])
			check("read word", fit(i == 0 ? e0 : e1), got[i]);
	endtask : read_expect

	initial begin
		#(80000 * 100);
		num_errors++;
		close_out();
	end

	initial begin
		logic [10:0] a;
		logic [10:0] last;
		logic [10:0] top;
		logic [15:0] d;
		clk_sys = 1'b0;
		rst = 1'b1;
		org_word = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = CMD_READ;
		cmd_addr = 11'h000;
		cmd_data = 16'h0000;
		cmd_words = 10'h000;
		num_errors = 0;
		comparisons = 0;
		seed = 24;
		for (int o = 1; o >= 0; o--) begin
			reset_dut(o[0]);
			// the top address bit is ignored, so it aliases to the low half
			last = org_word ? 11'h1ff : 11'h3ff;
			top = org_word ? 11'h200 : 11'h400;
			run(CMD_PROGRAM_ENABLE, 11'h000, 16'h0000, 10'h000);
			run(CMD_CLEAR_WHOLE_ARRAY, 11'h000, 16'h0000, 10'h000);
			read_expect(11'h000, 16'hffff, 16'hffff, 3);
			run(CMD_PROGRAM_DISABLE, 11'h000, 16'h0000, 10'h000);
			run(CMD_WRITE, 11'h005, 16'h1234, 10'h000);
			read_expect(11'h005, 16'hffff, 16'hffff, 1);
			run(CMD_PROGRAM_ENABLE, 11'h000, 16'h0000, 10'h000);
			run(CMD_PROGRAM_WHOLE_ARRAY, 11'h000, 16'ha5c3, 10'h000);
			run(CMD_WRITE, top, 16'h0f0f, 10'h000);
			read_expect(last | top, 16'ha5c3, 16'h0f0f, 2);
			run(CMD_CLEAR, 11'h005 | top, 16'h0000, 10'h000);
			read_expect(11'h005, 16'hffff, 16'ha5c3, 2);
			repeat (6) begin
				a = 11'($random(seed)) & last;
				d = 16'($random(seed));
				if ($random(seed) & 1)
					a = a | top;
				run(CMD_WRITE, a, d, 10'h000);
				read_expect(a & last, d, d, 1);
			end
		end
		close_out();
	end
endmodule : sec_bench
